// File: hw/rcl_core.sv
// Purpose: code registers, power-up reload and port arbitration
// Assumes: nvm answers each word with a one-cycle nvm_done
// Notes: serial side runs on link_clk, the rest on clk
`timescale 1ns/1ps
module rcl_core #(
   parameter int LOAD_MAX_CYC = rcl_pkg::LOAD_MAX_CYC
) (
   input wire logic clk,                      // core clock
   input wire logic sys_rst,                  // async reset, high
   input wire logic link_clk,                 // serial side clock
   input wire logic link_cmd_valid,           // command offered
   input rcl_pkg::rcl_link_cmd_s link_cmd,    // command word
   output logic link_cmd_ready,               // command taken
   output logic link_resp_valid,              // answer pulse
   output rcl_pkg::rcl_link_resp_s link_resp, // answer word
   input wire logic iface_enable,             // adjust enable pin
   input wire logic pulse_adjust_line_up,     // step up pulse
   input wire logic pulse_adjust_line_down,   // step down pulse
   input wire logic pulse_adjust_line_store,  // store pulse
   input wire logic over_temp,                // die overheat flag
   input wire logic prog_supply_ok,           // supply fit to store
   output rcl_pkg::rcl_nvm_req_s nvm,         // nvm request
   input wire logic nvm_done,                 // nvm word finished
   input rcl_pkg::rcl_code_t nvm_rdata,       // nvm read word
   output rcl_pkg::rcl_code_t [10:0] ch_code, // channel codes
   output logic [9:0] gamma_buf_en,           // gamma buffer enables
   output logic common_amp_en,                // common amp enable
   output logic load_done,                    // reload finished
   output logic load_timeout                  // reload cut short
);
   // ------------------------------------------------
   // local names
   // ------------------------------------------------
   localparam int SY_REQ = 0;  // link request toggle
   localparam int SY_EN = 1;   // adjust enable
   localparam int SY_UP = 2;   // step up
   localparam int SY_DN = 3;   // step down
   localparam int SY_ST = 4;   // store
   localparam int SY_OT = 5;   // overheat
   localparam int SY_SUP = 6;  // store supply
   localparam int SY_W = 7;
   localparam logic [14:0] TMR_LAST = 15'(LOAD_MAX_CYC - 1);
   localparam logic [3:0] CI = rcl_pkg::COMMON_IDX;

   // core domain state
   typedef struct packed {
      rcl_pkg::rcl_core_st_e st;                  // sequencer state
      rcl_pkg::rcl_code_t [10:0] code;            // code registers
      rcl_pkg::rcl_nvm_req_s nvm;                 // nvm request
      logic [3:0] last;                           // last word
      logic link_own;                             // serial owns seq
      logic loaded;                               // reload finished
      logic tmout;                                // reload cut short
      logic [14:0] tmr;                           // reload timer
      logic req_seen;                             // last request toggle
      logic ack_tgl;                              // answer toggle
      rcl_pkg::rcl_link_resp_s resp;              // held answer
      logic up_prev;                              // edge memories
      logic dn_prev;
      logic st_prev;
      logic [9:0] gbuf;                           // gamma enables
   } rcl_core_s;

   // link domain state
   typedef struct packed {
      logic pend;                        // waiting for answer
      logic req_tgl;                     // request toggle
      rcl_pkg::rcl_link_cmd_s cmd;       // held command
      logic ack_seen;                    // last answer toggle
      logic rvalid;                      // answer pulse
      rcl_pkg::rcl_link_resp_s resp;     // answer copy
   } rcl_link_s;

   rcl_core_s q;
   rcl_core_s d;
   rcl_link_s lq;
   rcl_link_s ld;
   logic [SY_W-1:0] s;   // synchronised inputs
   logic ack_s;          // answer toggle on link side
   logic link_new;       // fresh serial command
   logic ev_up;          // qualified adjust events
   logic ev_dn;
   logic ev_st;
   logic ch_ok;          // command channel exists

   // start one nvm sequence at word first
   function automatic rcl_pkg::rcl_nvm_req_s nvm_start(input logic we, input logic [3:0] first,
                                                       input rcl_pkg::rcl_code_t w);
      nvm_start = '{req: 1'b1, we: we, addr: first, wdata: w};
   endfunction

   // ------------------------------------------------
   // crossings into the core clock
   // ------------------------------------------------
   // every adjust, sensor and supply pin and the link toggle pass two flops here
   rcl_sync #(.W(SY_W)) u_sync_core (
      .clk(clk),
      .rst(sys_rst),
      .din({prog_supply_ok, over_temp, pulse_adjust_line_store, pulse_adjust_line_down,
            pulse_adjust_line_up, iface_enable, lq.req_tgl}),
      .dout(s)
   );

   // answer toggle back to the link clock
   rcl_sync #(.W(1)) u_sync_link (
      .clk(link_clk),
      .rst(sys_rst),
      .din(q.ack_tgl),
      .dout(ack_s)
   );

   // ------------------------------------------------
   // event decode
   // ------------------------------------------------
   // edges come from the settled stage and its memory
   always_comb begin
      link_new = s[SY_REQ] != q.req_seen;
      ev_up = s[SY_EN] & s[SY_UP] & ~q.up_prev;
      ev_dn = s[SY_EN] & s[SY_DN] & ~q.dn_prev;
      ev_st = s[SY_EN] & s[SY_ST] & ~q.st_prev;
      ch_ok = lq.cmd.ch <= CI;
   end

   // ------------------------------------------------
   // core next state
   // ------------------------------------------------
   always_comb begin
      d = q;
      // edge memories follow always, so edges seen while
      // busy are used up and never replayed later
      d.up_prev = s[SY_UP];
      d.dn_prev = s[SY_DN];
      d.st_prev = s[SY_ST];
      // the sensor flag carries its own hysteresis
      d.gbuf = s[SY_OT] ? rcl_pkg::GAMMA_MID_ONLY : rcl_pkg::GAMMA_ALL_ON;
      if (!q.loaded) begin
         d.tmr = q.tmr + rcl_pkg::TMR_ONE;
      end
      unique case (q.st)
         // reset left every code at zero; fetch all words
         rcl_pkg::CS_START: begin
            d.st = rcl_pkg::CS_SEQ;
            d.nvm = nvm_start(1'b0, rcl_pkg::IDX_ZERO, rcl_pkg::CODE_MIN);
            d.last = CI;
            d.link_own = 1'b0;
         end
         // one word per nvm_done, state busy until the last
         rcl_pkg::CS_SEQ: begin
            if (nvm_done) begin
               if (!q.nvm.we) begin
                  d.code[q.nvm.addr] = nvm_rdata;
               end
               if (q.nvm.addr == q.last) begin
                  d.nvm.req = 1'b0;
                  d.st = rcl_pkg::CS_IDLE;
                  d.loaded = 1'b1;
               end else begin
                  d.nvm.addr = q.nvm.addr + rcl_pkg::IDX_ONE;
                  d.nvm.wdata = q.code[q.nvm.addr + rcl_pkg::IDX_ONE];
               end
            end
         end
         // serial command first, adjust events only otherwise
         rcl_pkg::CS_IDLE: begin
            if (link_new) begin
               // decoded in the answer block below
            end else if (ev_up || ev_dn) begin
               // only the common code is reachable here
               d.code[CI] = rcl_pkg::code_step(q.code[CI], ev_up);
            end else if (ev_st && s[SY_SUP]) begin
               d.st = rcl_pkg::CS_SEQ;
               d.nvm = nvm_start(1'b1, CI, q.code[CI]);
               d.last = CI;
               d.link_own = 1'b0;
            end
         end
         default: begin
            d.st = rcl_pkg::CS_IDLE;  // illegal code recovers
         end
      endcase
      // every serial command gets an answer; a busy or
      // unloaded core answers without acknowledge
      if (link_new) begin
         d.req_seen = s[SY_REQ];
         d.ack_tgl = ~q.ack_tgl;
         d.resp = '0;
         if (q.st == rcl_pkg::CS_IDLE) begin
            unique case (lq.cmd.op)
               rcl_pkg::OP_WRITE: begin
                  if (ch_ok) begin
                     d.code[lq.cmd.ch] = lq.cmd.data;
                     d.resp.acked = 1'b1;
                  end
               end
               rcl_pkg::OP_READ: begin
                  if (ch_ok) begin
                     d.resp.rdata = q.code[lq.cmd.ch];
                     d.resp.acked = 1'b1;
                  end
               end
               rcl_pkg::OP_STORE_GAMMA, rcl_pkg::OP_STORE_COMMON,
               rcl_pkg::OP_RECALL_GAMMA, rcl_pkg::OP_RECALL_COMMON: begin
                  d.resp.acked = 1'b1;
                  // a weak supply still acknowledges but stores nothing
                  if (s[SY_SUP] || lq.cmd.op[2]) begin
                     d.st = rcl_pkg::CS_SEQ;
                     d.link_own = 1'b1;
                     d.last = lq.cmd.op[0] ? CI : rcl_pkg::GAMMA_LAST;
                     d.nvm = nvm_start(~lq.cmd.op[2], lq.cmd.op[0] ? CI : rcl_pkg::IDX_ZERO,
                                       lq.cmd.op[0] ? q.code[CI] : q.code[0]);
                  end
               end
               default: begin
                  d.resp.acked = 1'b0;  // unknown command
               end
            endcase
         end
      end
      // reload ceiling: give up and free the ports
      if (!q.loaded && q.tmr == TMR_LAST) begin
         d.loaded = 1'b1;
         d.tmout = 1'b1;
         d.nvm.req = 1'b0;
         d.st = rcl_pkg::CS_IDLE;
      end
   end

   // core registers; reset clears every code
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   // ------------------------------------------------
   // link side
   // ------------------------------------------------
   // command is held in lq.cmd while pending, so the core
   // may read it after the toggle has settled
   always_comb begin
      ld = lq;
      ld.rvalid = 1'b0;
      if (link_cmd_valid && !lq.pend) begin
         ld.cmd = link_cmd;
         ld.req_tgl = ~lq.req_tgl;
         ld.pend = 1'b1;
      end
      if (lq.pend && ack_s != lq.ack_seen) begin
         ld.ack_seen = ack_s;
         ld.pend = 1'b0;
         ld.rvalid = 1'b1;
         ld.resp = q.resp;  // stable until next request
      end
   end

   // link registers
   always_ff @(posedge link_clk or posedge sys_rst) begin
      if (sys_rst) begin
         lq <= '0;
      end else begin
         lq <= ld;
      end
   end

   // ------------------------------------------------
   // outputs
   // ------------------------------------------------
   assign link_cmd_ready = !lq.pend;
   assign link_resp_valid = lq.rvalid;
   assign link_resp = lq.resp;
   assign nvm = q.nvm;
   assign ch_code = q.code;
   assign gamma_buf_en = q.gbuf;
   assign common_amp_en = 1'b1;
   assign load_done = q.loaded;
   assign load_timeout = q.tmout;

   // ------------------------------------------------
   // checks
   // ------------------------------------------------
   property p_sat_top;
      @(posedge clk) disable iff (sys_rst)
      (q.st == rcl_pkg::CS_IDLE && !link_new && ev_up && q.code[CI] == rcl_pkg::CODE_MAX)
      |=> q.code[CI] == rcl_pkg::CODE_MAX;
   endproperty
   a_sat_top: assert property (p_sat_top) else $error("common code wrapped");

   property p_gate;
      @(posedge clk) disable iff (sys_rst)
      (q.st == rcl_pkg::CS_IDLE && !link_new && !s[SY_EN]) |=> $stable(q.code);
   endproperty
   a_gate: assert property (p_gate) else $error("adjust acted while disabled");

   property p_step;
      @(posedge clk) disable iff (sys_rst)
      (q.st == rcl_pkg::CS_IDLE && !link_new && ev_up && q.code[CI] != rcl_pkg::CODE_MAX)
      |=> q.code[CI] == $past(q.code[CI]) + rcl_pkg::CODE_ONE;
   endproperty
   a_step: assert property (p_step) else $error("step up missed");

   property p_boot;
      @(posedge clk) disable iff (sys_rst)
      q.st == rcl_pkg::CS_START |-> q.code == '0 ##1
      (q.st == rcl_pkg::CS_SEQ && q.nvm.req && !q.nvm.we && q.nvm.addr == rcl_pkg::IDX_ZERO);
   endproperty
   a_boot: assert property (p_boot) else $error("reload did not start");

   property p_bound;
      @(posedge clk) disable iff (sys_rst)
      !q.loaded |-> q.tmr <= TMR_LAST;
   endproperty
   a_bound: assert property (p_bound) else $error("reload overran");

   property p_nak;
      @(posedge clk) disable iff (sys_rst)
      (link_new && q.st != rcl_pkg::CS_IDLE) |=> !q.resp.acked && q.ack_tgl != $past(q.ack_tgl);
   endproperty
   a_nak: assert property (p_nak) else $error("busy command acknowledged");

   property p_heat;
      @(posedge clk) disable iff (sys_rst)
      s[SY_OT] |=> gamma_buf_en == rcl_pkg::GAMMA_MID_ONLY && common_amp_en;
   endproperty
   a_heat: assert property (p_heat) else $error("overheat mask wrong");

   property p_cool;
      @(posedge clk) disable iff (sys_rst)
      !s[SY_OT] |=> gamma_buf_en == rcl_pkg::GAMMA_ALL_ON;
   endproperty
   a_cool: assert property (p_cool) else $error("buffers not restored");

   property p_write;
      @(posedge clk) disable iff (sys_rst)
      (link_new && q.st == rcl_pkg::CS_IDLE && lq.cmd.op == rcl_pkg::OP_WRITE && ch_ok)
      |=> q.resp.acked && q.code[$past(lq.cmd.ch)] == $past(lq.cmd.data);
   endproperty
   a_write: assert property (p_write) else $error("serial write lost");

   property p_gamma_safe;
      @(posedge clk) disable iff (sys_rst)
      (q.st == rcl_pkg::CS_IDLE && !link_new) |=> $stable(q.code[9:0]);
   endproperty
   a_gamma_safe: assert property (p_gamma_safe) else $error("adjust touched gamma");

   property p_seq_hold;
      @(posedge clk) disable iff (sys_rst)
      (q.st == rcl_pkg::CS_SEQ && q.nvm.we) |=> $stable(q.code);
   endproperty
   a_seq_hold: assert property (p_seq_hold) else $error("codes moved during store");

   property p_release;
      @(posedge clk) disable iff (sys_rst)
      (q.st == rcl_pkg::CS_SEQ && nvm_done && q.nvm.addr == q.last)
      |=> q.st == rcl_pkg::CS_IDLE && !q.nvm.req;
   endproperty
   a_release: assert property (p_release) else $error("no release after sequence");

   c_loaded: cover property (@(posedge clk) disable iff (sys_rst) $rose(q.loaded) && !q.tmout);
   c_write: cover property (@(posedge clk) disable iff (sys_rst)
      link_new && q.st == rcl_pkg::CS_IDLE && lq.cmd.op == rcl_pkg::OP_WRITE);
   c_step: cover property (@(posedge clk) disable iff (sys_rst)
      q.st == rcl_pkg::CS_IDLE && !link_new && ev_dn);
   c_pstore: cover property (@(posedge clk) disable iff (sys_rst)
      q.st == rcl_pkg::CS_SEQ && !q.link_own && q.loaded);
endmodule

// File: hw/rcl_sync.sv
// Purpose: two-flop level synchroniser, any width
// Assumes: each bit is a slow level or a toggle
// Notes: multi-bit words must not be sent through it
`timescale 1ns/1ps
module rcl_sync #(
   parameter int W = 1
) (
   input wire logic clk,           // destination clock
   input wire logic rst,           // async reset, high
   input wire logic [W-1:0] din,   // foreign levels
   output logic [W-1:0] dout       // settled levels
);
   typedef struct packed {
      logic [W-1:0] meta;   // first stage, read only below
      logic [W-1:0] stab;   // second stage
   } rcl_sync_s;
   rcl_sync_s q;
   rcl_sync_s d;

   // next state: shift one stage
   always_comb begin
      d.meta = din;
      d.stab = q.meta;
   end

   // registers
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign dout = q.stab;
endmodule

// File: inc/rcl_pkg.sv
// Purpose: constants and types shared by the reference code loader
// Assumes: 50 MHz core clock; ten gamma channels and one common channel
// Notes: channel 10 is the common-electrode code, 0..9 are gamma codes
// How it works
// - every channel holds one 10-bit code, 0..1023
// - adjust line obeyed only while enable high
// - adjust pulses step common code, may store it
// - power-up copies stored codes into registers
// - reset clears codes, release reloads them
// - reload finishes within 400 us
// - no serial acknowledge before reload completes
// - overheat leaves only middle gamma pair on
// - cooling re-enables every gamma buffer
// - common amplifier never disabled by overheat
// - serial port writes codes, triggers nvm store
// - adjust line touches only common code
// - one interface acts only while other idle
// - adjust activity dropped during serial command
// - serial commands refused during adjust command
package rcl_pkg;
   // ------------------------------------------------
   // sizes
   // ------------------------------------------------
   localparam int CODE_W = 10;     // code width
   localparam int NUM_GAMMA = 10;  // gamma channels
   localparam int NUM_CH = 11;     // gamma plus common
   localparam int IDX_W = 4;       // channel index width
   localparam logic [3:0] IDX_ZERO = 4'h0;
   localparam logic [3:0] IDX_ONE = 4'h1;
   localparam logic [3:0] GAMMA_LAST = 4'h9;
   localparam logic [3:0] COMMON_IDX = 4'ha;
   // code limits, the common code saturates at them
   localparam logic [9:0] CODE_MAX = 10'h3ff;
   localparam logic [9:0] CODE_MIN = 10'h000;
   localparam logic [9:0] CODE_ONE = 10'h001;
   // gamma buffer enables: all, or middle pair only
   localparam logic [9:0] GAMMA_ALL_ON = 10'h3ff;
   localparam logic [9:0] GAMMA_MID_ONLY = 10'h030;
   // ------------------------------------------------
   // timing
   // ------------------------------------------------
   localparam int CLK_MHZ = 50;       // core clock rate
   localparam int LOAD_TYP_US = 300;  // usual reload time
   localparam int LOAD_MAX_US = 400;  // reload ceiling
   localparam int LOAD_MAX_CYC = LOAD_MAX_US * CLK_MHZ;
   localparam int TMR_W = 15;         // holds 20000
   localparam logic [14:0] TMR_ONE = 15'h0001;
   localparam int NVM_LIFE_WRITES = 300; // far-side budget
   // ------------------------------------------------
   // types
   // ------------------------------------------------
   typedef logic [CODE_W-1:0] rcl_code_t;
   typedef enum logic [2:0] {
      OP_WRITE = 3'h0,         // write one code
      OP_READ = 3'h1,          // read one code
      OP_STORE_GAMMA = 3'h2,   // gamma codes to nvm
      OP_STORE_COMMON = 3'h3,  // common code to nvm
      OP_RECALL_GAMMA = 3'h4,  // nvm to gamma codes
      OP_RECALL_COMMON = 3'h5  // nvm to common code
   } rcl_op_e;
   typedef enum logic [1:0] {
      CS_START = 2'h0,  // begin power-up reload
      CS_SEQ = 2'h1,    // nvm word sequence running
      CS_IDLE = 2'h2    // waiting for either interface
   } rcl_core_st_e;
   typedef struct packed {
      rcl_op_e op;             // command
      logic [IDX_W-1:0] ch;    // channel index
      rcl_code_t data;         // write data
   } rcl_link_cmd_s;
   typedef struct packed {
      logic acked;             // command acknowledged
      rcl_code_t rdata;        // read data
   } rcl_link_resp_s;
   typedef struct packed {
      logic req;               // word request
      logic we;                // store when high
      logic [IDX_W-1:0] addr;  // nvm word index
      rcl_code_t wdata;        // word to store
   } rcl_nvm_req_s;

   // saturating one-step move of a code
   function automatic rcl_code_t code_step(input rcl_code_t c, input logic up);
      if (up) begin
         code_step = (c == CODE_MAX) ? CODE_MAX : c + CODE_ONE;
      end else begin
         code_step = (c == CODE_MIN) ? CODE_MIN : c - CODE_ONE;
      end
   endfunction
endpackage

// File: tb/rcl_nvm_model.sv
// Purpose: slow nvm array that answers the core's word requests
// Assumes: each word finishes 16 core clocks after it is requested
// Notes: read data is inverted outside the done cycle
`timescale 1ns/1ps
module rcl_nvm_model (
   input wire logic clk, // core clock
   input rcl_pkg::rcl_nvm_req_s nvm, // word request
   output logic nvm_done, // word finished
   output rcl_pkg::rcl_code_t nvm_rdata // read word
);
   rcl_pkg::rcl_code_t mem [0:15]; // stored words
   logic [3:0] wait_q = 4'h0; // answer delay count
   int n_commits = 0; // words committed so far
   // preload a distinct word per channel
   initial begin
      for (int i = 0; i < 16; i++) begin
         mem[i] = 10'h2a0 + 10'(i);
      end
   end
   // slow answers keep a busy core busy long enough to collide with
   always @(posedge clk) begin
      nvm_done <= 1'b0;
      if (nvm.req === 1'b1 && !nvm_done) begin
         wait_q <= wait_q + 4'h1;
         if (wait_q == 4'hf) begin
            nvm_done <= 1'b1;
            if (nvm.we) begin
               mem[nvm.addr] <= nvm.wdata;
               n_commits <= n_commits + 1;
            end
         end
      end
   end
   // stale data never looks valid
   assign nvm_rdata = nvm_done ? mem[nvm.addr] : ~mem[nvm.addr];
endmodule

// File: tb/tb.sv
// Purpose: self-checking bench for the code loader core
// Assumes: nvm model answers each word after 16 clocks
// Notes: reload ceiling shortened to 400 cycles
`timescale 1ns/1ps
module tb;
   // -------------------------------------------
   // signals
   // -------------------------------------------
   typedef struct packed {
      rcl_pkg::rcl_op_e op; // command
      logic [3:0] ch; // channel
      rcl_pkg::rcl_code_t code; // data or expected read
      logic ack; // expected acknowledge
   } rcl_row_s;
   rcl_row_s rows [7] = '{'{rcl_pkg::OP_WRITE, 4'h0, 10'h000, 1'b1},
      '{rcl_pkg::OP_WRITE, 4'h9, 10'h3ff, 1'b1}, '{rcl_pkg::OP_WRITE, 4'h5, 10'h2aa, 1'b1},
      '{rcl_pkg::OP_WRITE, 4'ha, 10'h3fe, 1'b1}, '{rcl_pkg::OP_WRITE, 4'hb, 10'h155, 1'b0},
      '{rcl_pkg::OP_READ, 4'h9, 10'h3ff, 1'b1}, '{rcl_pkg::rcl_op_e'(3'h6), 4'h1, 10'h000, 1'b0}};
   logic clk = 1'b0; // core clock
   logic link_clk = 1'b1; // serial clock, idles high
   logic link_on = 1'b1; // serial clock runs
   logic sys_rst = 1'b1; // reset
   logic link_cmd_valid = 1'b0; // command offered
   rcl_pkg::rcl_link_cmd_s link_cmd = '0; // command word
   logic link_cmd_ready; // command taken
   logic link_resp_valid; // answer pulse
   rcl_pkg::rcl_link_resp_s link_resp; // answer word
   rcl_pkg::rcl_link_resp_s got; // last answer
   logic iface_enable = 1'b0; // adjust enable
   logic [2:0] adj_pins = 3'h0; // up, down, store
   logic over_temp = 1'b0; // overheat flag
   logic prog_supply_ok = 1'b0; // supply fit, off while loading
   rcl_pkg::rcl_nvm_req_s nvm; // nvm request
   logic nvm_done; // nvm word done
   rcl_pkg::rcl_code_t nvm_rdata; // nvm word
   rcl_pkg::rcl_code_t [10:0] ch_code; // codes
   logic [9:0] gamma_buf_en; // buffer enables
   logic common_amp_en; // common amp on
   logic load_done; // reload done
   logic load_timeout; // reload cut short
   int miscompares = 0; // mismatches
   int n_tests = 0; // comparisons
   always #10 clk = ~clk;
   // serial clock stands high between frames, off phase from clk
   always begin
      #1.7;
      forever #3 link_clk = link_on ? ~link_clk : 1'b1;
   end
   rcl_core #(.LOAD_MAX_CYC(400)) u_rcl_core (.clk(clk), .sys_rst(sys_rst), .link_clk(link_clk),
      .link_cmd_valid(link_cmd_valid), .link_cmd(link_cmd), .link_cmd_ready(link_cmd_ready),
      .link_resp_valid(link_resp_valid), .link_resp(link_resp), .iface_enable(iface_enable),
      .pulse_adjust_line_up(adj_pins[0]), .pulse_adjust_line_down(adj_pins[1]),
      .pulse_adjust_line_store(adj_pins[2]), .over_temp(over_temp), .prog_supply_ok(prog_supply_ok),
      .nvm(nvm), .nvm_done(nvm_done), .nvm_rdata(nvm_rdata), .ch_code(ch_code),
      .gamma_buf_en(gamma_buf_en), .common_amp_en(common_amp_en), .load_done(load_done),
      .load_timeout(load_timeout));
   rcl_nvm_model u_rcl_nvm_model (.clk(clk), .nvm(nvm), .nvm_done(nvm_done), .nvm_rdata(nvm_rdata));
   // -------------------------------------------
   // tasks
   // -------------------------------------------
   task automatic chk(input string nm, input logic [10:0] seen, input logic [10:0] exp);
      n_tests++;
      if (seen !== exp) begin
         miscompares++;
         $display("BAD %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic print_verdict();
      $display("comparisons %0d mismatches %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   task automatic settle(input int cyc);
      repeat (cyc) @(negedge clk);
   endtask
   // one command, held to its taking edge, then its answer
   task automatic send(input rcl_pkg::rcl_op_e op, input logic [3:0] ch, input rcl_pkg::rcl_code_t d);
      int n = 0;
      link_on = 1'b1;
      @(negedge link_clk);
      link_cmd = '{op: op, ch: ch, data: d};
      link_cmd_valid = 1'b1;
      @(posedge link_clk);
      @(negedge link_clk);
      chk("ready", {10'h000, link_cmd_ready}, 11'h000);
      link_cmd_valid = 1'b0;
      while (link_resp_valid !== 1'b1 && n < 80) begin
         @(negedge link_clk);
         n++;
      end
      got = link_resp;
      chk("answer", {10'h000, link_resp_valid}, 11'h001);
      @(negedge link_clk);
      link_on = 1'b0;
   endtask
   // bounded wait for reload or store to end
   task automatic wait_idle();
      int n = 0;
      settle(2);
      while ((load_done !== 1'b1 || nvm.req !== 1'b0) && n < 600) begin
         @(negedge clk);
         n++;
      end
      chk("idle", {9'h000, load_done, nvm.req}, 11'h002);
      settle(2);
   endtask
   // one adjust event, spaced well apart
   task automatic adj(input int k);
      @(negedge clk);
      adj_pins[k] = 1'b1;
      settle(5);
      adj_pins[k] = 1'b0;
      settle(5);
   endtask
   // -------------------------------------------
   // main sequence and watchdog
   // -------------------------------------------
   initial begin
      #100000;
      miscompares++;
      print_verdict();
   end
   initial begin
      settle(20);
      sys_rst = 1'b0;
      send(rcl_pkg::OP_READ, 4'h0, 10'h000);
      chk("early_ack", {10'h000, got.acked}, 11'h000);
      wait_idle();
      chk("timeout", {10'h000, load_timeout}, 11'h000);
      prog_supply_ok = 1'b1;
      for (int i = 0; i < 11; i++) begin
         chk("reload", {1'b0, ch_code[i]}, {1'b0, 10'h2a0 + 10'(i)});
      end
      foreach (rows[r]) begin
         send(rows[r].op, rows[r].ch, rows[r].code);
         if (rows[r].op == rcl_pkg::OP_READ) begin
            chk("read", got, {rows[r].ack, rows[r].code});
         end else begin
            chk("ack", {10'h000, got.acked}, {10'h000, rows[r].ack});
         end
      end
      chk("buf_on", {1'b0, gamma_buf_en}, 11'h3ff);
      settle(1);
      over_temp = 1'b1;
      settle(6);
      chk("buf_hot", {1'b0, gamma_buf_en}, 11'h030);
      chk("amp_hot", {10'h000, common_amp_en}, 11'h001);
      over_temp = 1'b0;
      settle(6);
      chk("buf_cool", {1'b0, gamma_buf_en}, 11'h3ff);
      adj(0);
      chk("adj_off", {1'b0, ch_code[10]}, 11'h3fe);
      iface_enable = 1'b1;
      settle(4);
      adj(0);
      chk("adj_up", {1'b0, ch_code[10]}, 11'h3ff);
      adj(0);
      chk("adj_sat", {1'b0, ch_code[10]}, 11'h3ff);
      adj(1);
      chk("adj_dn", {1'b0, ch_code[10]}, 11'h3fe);
      send(rcl_pkg::OP_STORE_GAMMA, 4'h0, 10'h000);
      chk("store_ack", {10'h000, got.acked}, 11'h001);
      adj(1);
      send(rcl_pkg::OP_WRITE, 4'h1, 10'h001);
      chk("busy_ack", {10'h000, got.acked}, 11'h000);
      wait_idle();
      chk("adj_drop", {1'b0, ch_code[10]}, 11'h3fe);
      chk("nvm_g9", {1'b0, u_rcl_nvm_model.mem[9]}, 11'h3ff);
      adj(2);
      send(rcl_pkg::OP_WRITE, 4'h1, 10'h001);
      chk("adj_busy", {10'h000, got.acked}, 11'h000);
      wait_idle();
      chk("nvm_com", {1'b0, u_rcl_nvm_model.mem[10]}, 11'h3fe);
      chk("nvm_g1", {1'b0, u_rcl_nvm_model.mem[1]}, 11'h2a1);
      send(rcl_pkg::OP_WRITE, 4'h5, 10'h001);
      send(rcl_pkg::OP_RECALL_GAMMA, 4'h0, 10'h000);
      chk("recall_ack", {10'h000, got.acked}, 11'h001);
      wait_idle();
      chk("recall_g5", {1'b0, ch_code[5]}, 11'h2aa);
      chk("budget", {10'h000, u_rcl_nvm_model.n_commits <= rcl_pkg::NVM_LIFE_WRITES}, 11'h001);
      sys_rst = 1'b1;
      prog_supply_ok = 1'b0;
      settle(3);
      chk("rst_code", {1'b0, ch_code[9]}, 11'h000);
      chk("rst_buf", {1'b0, gamma_buf_en}, 11'h000);
      sys_rst = 1'b0;
      wait_idle();
      chk("again_g9", {1'b0, ch_code[9]}, 11'h3ff);
      chk("again_com", {1'b0, ch_code[10]}, 11'h3fe);
      print_verdict();
   end
endmodule
